// [hdl/sacr_top.sv]
`timescale 1ns/100ps
// What this block does
// - convert_start_n falling with chip select low puts sample-hold into hold and starts conversion.
// - busy rises as conversion begins and stays high throughout.
// - busy falls once the result is latched into the output register.
// - data presented only while chip select and read strobe are both low.
// - half select 0 gives bits 15..0; 1 gives bits 15..8 on low lanes.
// - half select steers lanes directly; read strobe may stay low.
// - conversion starts at first conversion clock rise; 16 rises then latch.
// - further convert_start_n falls are ignored during a conversion.
// - data lines are high impedance unless chip select and read both low.
// - result word is binary twos complement.
module sacr_top
   import sacr_pkg::*;
(
   input  wire logic                     sys_clk_in,
   input  wire logic                     reset_in,
   input  wire logic                     conv_clk_in,
   input  wire logic                     convert_start_n_in,
   input  wire logic                     chip_select_n_in,
   input  wire logic                     read_n_in,
   input  wire logic                     half_select_in,
   input  wire logic [SACR_RESULT_W-1:0] sample_code_in,
   output logic                          hold_out,
   output logic                          busy_out,
   output logic [SACR_RESULT_W-1:0]      result_lines_out,
   output logic [SACR_RESULT_W-1:0]      result_lines_oe_out
);
   ////////////////////////////////////////////////////////////////////////////
   sacr_state_t               state_reg, state_next;
   logic                      convert_start_n_d_reg;
   logic                      conv_clk_d_reg;
   logic [SACR_CNT_W-1:0]     edge_cnt_reg, edge_cnt_next;
   logic [SACR_RESULT_W-1:0]  sample_reg, sample_next;
   logic [SACR_RESULT_W-1:0]  result_reg, result_next;
   logic                      hold_reg, busy_reg;
   logic [SACR_RESULT_W-1:0]  lines_reg, oe_reg;

   wire start_fall = convert_start_n_d_reg & ~convert_start_n_in & ~chip_select_n_in;
   wire clk_rise   = ~conv_clk_d_reg & conv_clk_in;
   wire last_edge  = clk_rise && (edge_cnt_reg == 5'(SACR_CONV_EDGES));
   wire read_en    = ~chip_select_n_in & ~read_n_in;
   // sample code already twos complement; passed unchanged
   wire [SACR_RESULT_W-1:0] lane_data = half_select_in ?
      {{SACR_HALF_W{1'b0}}, result_reg[15:8]} : result_reg;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next   = state_reg;
      edge_cnt_next = edge_cnt_reg;
      sample_next  = sample_reg;
      result_next  = result_reg;
      unique case (state_reg)
         SACR_IDLE: begin
            if (start_fall) begin
               sample_next = sample_code_in;
               state_next  = SACR_ARMED;
            end
         end
         SACR_ARMED: begin
            if (clk_rise) begin
               edge_cnt_next = 5'h01;
               state_next    = SACR_CONVERT;
            end
         end
         SACR_CONVERT: begin
            if (last_edge) begin
               result_next   = sample_reg;
               edge_cnt_next = SACR_CNT_RST;
               state_next    = SACR_IDLE;
            end else if (clk_rise) begin
               edge_cnt_next = edge_cnt_reg + 5'h01;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         state_reg      <= SACR_IDLE;
         convert_start_n_d_reg   <= 1'b1;
         conv_clk_d_reg <= 1'b0;
         edge_cnt_reg   <= SACR_CNT_RST;
         sample_reg     <= SACR_RESULT_RST;
         result_reg     <= SACR_RESULT_RST;
         hold_reg       <= 1'b0;
         busy_reg       <= 1'b0;
         lines_reg      <= SACR_RESULT_RST;
         oe_reg         <= SACR_RESULT_RST;
      end else begin
         state_reg      <= state_next;
         convert_start_n_d_reg   <= convert_start_n_in;
         conv_clk_d_reg <= conv_clk_in;
         edge_cnt_reg   <= edge_cnt_next;
         sample_reg     <= sample_next;
         result_reg     <= result_next;
         hold_reg       <= (state_next != SACR_IDLE);
         busy_reg       <= (state_next != SACR_IDLE);
         lines_reg      <= read_en ? lane_data : SACR_RESULT_RST;
         oe_reg         <= read_en ? 16'hffff : 16'h0000;
      end
   end

   assign hold_out            = hold_reg;
   assign busy_out            = busy_reg;
   assign result_lines_out    = lines_reg;
   assign result_lines_oe_out = oe_reg;

   ////////////////////////////////////////////////////////////////////////////
   // tally of conversion clock rises kept apart from the state machine,
   // so the latch point is checked by a second, independent count
   logic [SACR_CNT_W-1:0] chk_rises_reg;
   wire                   start_refused =
      convert_start_n_d_reg & ~convert_start_n_in & chip_select_n_in;

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         chk_rises_reg <= SACR_CNT_RST;
      end else if (!busy_reg) begin
         chk_rises_reg <= SACR_CNT_RST;
      end else if (clk_rise) begin
         chk_rises_reg <= chk_rises_reg + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_busy_rise: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (state_reg == SACR_IDLE && start_fall) |=> busy_out)
      else $error("busy did not rise after start");
   a_busy_hold: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (busy_out && !$past(last_edge)) |-> ##0 (state_reg != SACR_IDLE))
      else $error("busy high with no conversion");
   a_busy_fall: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      last_edge |=> (!busy_out && result_reg == $past(sample_reg)))
      else $error("busy not low after latch");
   a_hold_start: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (state_reg == SACR_IDLE && start_fall) |=> hold_out)
      else $error("hold not entered");
   a_start_ign: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (state_reg == SACR_CONVERT && !last_edge) |=> $stable(sample_reg))
      else $error("start accepted mid conversion");
   a_edge_count: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      last_edge |-> edge_cnt_reg == 5'd16)
      else $error("latch not on sixteenth edge");
   a_result_keep: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !last_edge |=> $stable(result_reg))
      else $error("result changed outside latch");
   a_tristate: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !read_en |=> (result_lines_oe_out == 16'h0000))
      else $error("lines driven while not read");
   a_lane_sel: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (read_en && half_select_in) |=>
         (result_lines_out == {8'h00, $past(result_reg[15:8])}))
      else $error("upper half not on low lanes");
   a_read_full: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (read_en && !half_select_in) |=>
         (result_lines_out == $past(result_reg) && result_lines_oe_out == 16'hffff))
      else $error("full word not presented");

   c_conv_done: cover property (@(posedge sys_clk_in) disable iff (reset_in) last_edge);
   c_half_read: cover property (@(posedge sys_clk_in) disable iff (reset_in)
      read_en && half_select_in ##1 read_en && !half_select_in);
   c_ignored:   cover property (@(posedge sys_clk_in) disable iff (reset_in)
      state_reg == SACR_CONVERT && start_fall);

   c_full_read: cover property (@(posedge sys_clk_in) disable iff (reset_in)
      read_en && !half_select_in);
   c_cs_refused: cover property (@(posedge sys_clk_in) disable iff (reset_in)
      state_reg == SACR_IDLE && start_refused);

   ////////////////////////////////////////////////////////////////////////////
   // conversion sequencing: first rise starts, sixteen more complete

   a_rise_count: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      $fell(busy_out) |->
         (chk_rises_reg == 5'(SACR_CONV_EDGES + 1)))
      else $error("busy fell on wrong clock rise");

   a_first_rise: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (state_reg == SACR_ARMED && clk_rise) |=>
         (state_reg == SACR_CONVERT && edge_cnt_reg == 5'h01))
      else $error("conversion did not begin on clock rise");

   a_armed_keep: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (state_reg == SACR_ARMED) |=>
         ($stable(sample_reg) && busy_out))
      else $error("start accepted while armed");

   a_busy_stay: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (busy_out && !last_edge) |=>
         busy_out)
      else $error("busy dropped mid conversion");

   a_hold_drop: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      last_edge |=>
         !hold_out)
      else $error("hold kept after latch");

   a_sample_take: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (state_reg == SACR_IDLE && start_fall) |=>
         (sample_reg == $past(sample_code_in)))
      else $error("sample not captured at start");

   a_cs_refuse: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (state_reg == SACR_IDLE && start_refused) |=>
         (!busy_out && !hold_out))
      else $error("start taken without chip select");

   ////////////////////////////////////////////////////////////////////////////
   // read path

   a_lanes_quiet: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !read_en |=>
         (result_lines_out == 16'h0000))
      else $error("lanes carry data while not read");

   a_read_drive: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      read_en |=>
         (result_lines_oe_out == 16'hffff))
      else $error("lanes not driven during read");
endmodule // sacr_top

// [include/sacr_pkg.sv]
package sacr_pkg;
   localparam int unsigned SACR_RESULT_W    = 16;
   localparam int unsigned SACR_HALF_W      = 8;
   localparam int unsigned SACR_CONV_EDGES  = 16;
   localparam int unsigned SACR_CNT_W       = 5;
   localparam logic [15:0] SACR_RESULT_RST  = 16'h0000;
   localparam logic [4:0]  SACR_CNT_RST     = 5'h00;
   localparam int unsigned SACR_CLK_MHZ     = 200;
   localparam int unsigned SACR_CONVERT_START_N_MIN_NS = 20;
   localparam int unsigned SACR_CONVERT_START_N_MIN_CYC =
      (SACR_CONVERT_START_N_MIN_NS * SACR_CLK_MHZ + 999) / 1000;
   typedef enum logic [1:0] {SACR_IDLE, SACR_ARMED, SACR_CONVERT} sacr_state_t;
endpackage

// [test/sacr_conv_clk_src.sv]
`timescale 1ns/100ps
module sacr_conv_clk_src #(parameter int HALF_NS = 50) (
   output logic conv_clk_out
);
   // free-running 10MHz conversion clock, top of the allowed band
   initial begin
      conv_clk_out = 1'b0;
      forever #(HALF_NS) conv_clk_out = ~conv_clk_out;
   end
endmodule // sacr_conv_clk_src

// [test/sar_adc_convert_and_parallel_readout_bench.sv]
`timescale 1ns/100ps
module sar_adc_convert_and_parallel_readout_bench;
   import sacr_pkg::*;
   logic        sys_clk, reset, conv_clk, cst_n, cs_n, rd_n, half, hold, busy;
   logic [15:0] code, lines, oe, v;
   logic [15:0] exp_q[$];
   int          n_fail = 0;
   int          n_checks = 0;
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   sacr_conv_clk_src #(.HALF_NS(50)) clk_u (.conv_clk_out(conv_clk));
   sacr_top dut_u (.sys_clk_in(sys_clk), .reset_in(reset), .conv_clk_in(conv_clk),
      .convert_start_n_in(cst_n), .chip_select_n_in(cs_n), .read_n_in(rd_n),
      .half_select_in(half), .sample_code_in(code), .hold_out(hold), .busy_out(busy),
      .result_lines_out(lines), .result_lines_oe_out(oe));
   ////////////////////////////////////////////////////////////////////////////////
   task check(input logic c, input string msg);
      n_checks++;
      if (c !== 1'b1) begin
         n_fail++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task summarize;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // low pulse of four cycles, 20ns at this clock
   task start(input logic cs_v, input logic [15:0] c);
      @(posedge sys_clk);
      cs_n <= cs_v;
      cst_n <= 1'b0;
      code <= c;
      repeat (4) @(posedge sys_clk);
      cst_n <= 1'b1;
   endtask
   // full word, then upper byte with read held low, then bus released
   task read_word(input logic [15:0] e);
      @(posedge sys_clk);
      {cs_n, rd_n, half} <= 3'h0;
      repeat (2) @(posedge sys_clk);
      exp_q.push_back(e);
      half <= 1'b1;
      repeat (2) @(posedge sys_clk);
      exp_q.push_back({8'h00, e[15:8]});
      {cs_n, rd_n, half} <= 3'h6;
      repeat (2) @(posedge sys_clk);
      check(oe === 16'h0000 && lines === 16'h0000, "lanes still driven after release");
   endtask
   task wait_done;
      int i;
      i = 0;
      while (busy !== 1'b0 && i < 400) begin
         @(negedge sys_clk);
         i++;
      end
      // seventeen rises of a 20-cycle clock, less the eight cycles already spent
      check(i >= 314 && i <= 333, "conversion length wrong");
   endtask
   always @(negedge sys_clk) begin
      if (exp_q.size() != 0) begin
         check(lines === exp_q[0], "read data mismatch");
         void'(exp_q.pop_front());
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {reset, cst_n, cs_n, rd_n, half, code} = {4'hf, 1'b0, 16'h0000};
      void'($urandom(32'hd646));
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check(busy === 1'b0 && oe === 16'h0000, "bad idle after reset");
      read_word(SACR_RESULT_RST);
      for (int k = 0; k < 3; k++) begin
         v = 16'($urandom);
         start(1'b0, v);
         check(busy === 1'b1 && hold === 1'b1, "no hold or busy on start");
         start(1'b0, ~v);
         wait_done();
         check(hold === 1'b0, "hold not released");
         read_word(v);
         start(1'b1, ~v);
         check(busy === 1'b0, "start taken without chip select");
         read_word(v);
         $display("test %0d done", k);
      end
      summarize();
   end
   initial begin
      #(5 * 5000);
      n_fail++;
      summarize();
   end
endmodule // sar_adc_convert_and_parallel_readout_bench
